// File: fci_pkg.sv
// Purpose: Shared constants for the flash command host controller
// Assumes: 40 MHz reference clock, byte-wide NOR flash on parallel pins
// Notes: Register offsets are byte addresses on the APB side
package fci_pkg;
  // Clock rate and bus timing
  localparam int CLK_MHZ = 40;
  localparam int T_PHASE_NS = 50;   // Setup, strobe low and hold phase of a write
  localparam int T_ACC_NS = 100;    // Read access time allowed before sampling
  localparam int T_RST_WAIT_US = 10; // Wait after read/reset issued in erase mode
  localparam int PHASE_CYC = (T_PHASE_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_WAIT_CYC = T_RST_WAIT_US * CLK_MHZ;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Control field positions
  localparam int CTRL_OP_LSB = 0;   // Two-bit operation code
  localparam int CTRL_START = 2;    // Write one to launch
  localparam int CTRL_ERASE = 3;    // Device is known to be in an erase mode
  localparam int CTRL_UNLOCK = 4;   // Precede read/reset with the unlock pair
  // Result field positions
  localparam int RES_BUSY = 8;
  localparam int RES_FAIL = 9;
  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  // Operations
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_RESET = 2'h1;
  localparam logic [1:0] OP_AUTO = 2'h2;
  localparam logic [1:0] OP_PROG = 2'h3;
  // Command cycle addresses and data
  localparam logic [11:0] UNLOCK1_ADDR = 12'h555;
  localparam logic [11:0] UNLOCK2_ADDR = 12'h2AA;
  localparam logic [11:0] CMD_ADDR = 12'h555;
  localparam logic [7:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [7:0] UNLOCK2_DATA = 8'h55;
  localparam logic [7:0] READ_RESET_CMD = 8'hF0;
  localparam logic [7:0] AUTO_SELECT_CMD = 8'h90;
  localparam logic [7:0] PROGRAM_CMD = 8'hA0;
  // Status byte flag positions
  localparam int POLLING_FLAG = 7;
  localparam int TOGGLE_FLAG = 6;
  localparam int ERROR_FLAG = 5;
  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // Controller states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_W_SET = 3'h1, ST_W_LOW = 3'h3, ST_W_HIGH = 3'h2,
    ST_R_SET = 3'h6, ST_R_CAP = 3'h7, ST_WAIT = 3'h5
  } fci_state_t;
endpackage

// File: fci_host.sv
// Purpose: Host controller driving an asynchronous NOR flash command interface
// Assumes: Flash data pins sampled synchronously; APB slave for software
// Notes: One operation at a time; start is ignored while busy
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module fci_host
  import fci_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic IRQ_O,
  output logic [19:0] FL_ADDR_O,
  input wire logic [7:0] FL_DQ_I,
  output logic [7:0] FL_DQ_O,
  output logic FL_DQ_OE_O,
  output logic FL_CE_N_O,
  output logic FL_OE_N_O,
  output logic FL_WE_N_O
);
  // Software-visible registers
  logic [4:0] ctrl_reg;        // Op, erase-mode and unlock choice
  logic [19:0] addr_reg;       // Target address
  logic [7:0] wdata_reg;       // Program data
  logic [7:0] rbyte_reg;       // Last byte read from the flash
  logic fail_reg;              // Last operation was a program that reported failure
  logic [1:0] stat_reg;        // Sticky events
  logic [1:0] mask_reg;        // Interrupt enables
  // Sequencer state
  fci_state_t state_reg;
  fci_state_t state_next;
  logic [8:0] cnt_reg;         // Phase counter, wide enough for the reset wait
  logic [1:0] idx_reg;         // Write cycle within the sequence
  logic retry_reg;             // Error flag seen once, re-read pending
  logic busy_reg;
  logic done_pulse;
  logic fail_pulse;
  // APB decode
  wire apb_acc = PSEL_I && PENABLE_I && !PREADY_O;
  // A write lands only at the completing edge, where the master samples ready high
  wire apb_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  // Order being written: a bare read/reset opens with the command itself
  wire first_bare = (PWDATA_I[CTRL_OP_LSB +: 2] == OP_RESET) && !PWDATA_I[CTRL_UNLOCK];
  wire hit_ctrl = PADDR_I == OFS_CTRL;
  wire hit_addr = PADDR_I == OFS_ADDR;
  wire hit_wdata = PADDR_I == OFS_WDATA;
  wire hit_res = PADDR_I == OFS_RESULT;
  wire hit_stat = PADDR_I == OFS_IRQ_STAT;
  wire hit_mask = PADDR_I == OFS_IRQ_MASK;
  wire hit_any = hit_ctrl | hit_addr | hit_wdata | hit_res | hit_stat | hit_mask;
  wire start = apb_wr && hit_ctrl && PWDATA_I[CTRL_START] && !busy_reg;
  wire [31:0] rd_mux =
    hit_ctrl ? {27'h0, ctrl_reg} :
    hit_addr ? {12'h0, addr_reg} :
    hit_wdata ? {24'h0, wdata_reg} :
    hit_res ? {22'h0, fail_reg, busy_reg, rbyte_reg} :
    hit_stat ? {30'h0, stat_reg} :
    hit_mask ? {30'h0, mask_reg} : RESET_WORD;
  // Sequence shape from the stored operation
  wire [1:0] op = ctrl_reg[CTRL_OP_LSB +: 2];
  wire unlock_path = (op != OP_RESET) || ctrl_reg[CTRL_UNLOCK];
  // Number of writes minus one; a bare reset is a single command write
  wire [1:0] last_idx = (op == OP_PROG) ? 2'h3 : unlock_path ? 2'h2 : 2'h0;
  wire has_writes = op != OP_READ;
  // Step index as seen on the command table
  wire [1:0] eff_idx = unlock_path ? idx_reg : 2'h2;
  wire [7:0] cmd_byte = (op == OP_PROG) ? PROGRAM_CMD :
    (op == OP_AUTO) ? AUTO_SELECT_CMD : READ_RESET_CMD;
  // Upper address lines are zero on command cycles; the device ignores them
  wire [19:0] step_addr =
    (eff_idx == 2'h0) ? {8'h0, UNLOCK1_ADDR} :
    (eff_idx == 2'h1) ? {8'h0, UNLOCK2_ADDR} :
    (eff_idx == 2'h2) ? {8'h0, CMD_ADDR} : addr_reg;
  wire [7:0] step_data =
    (eff_idx == 2'h0) ? UNLOCK1_DATA :
    (eff_idx == 2'h1) ? UNLOCK2_DATA :
    (eff_idx == 2'h2) ? cmd_byte : wdata_reg;
  // Per-state dwell and its end
  wire [8:0] lim = (state_reg == ST_WAIT) ? 9'(RST_WAIT_CYC - 1) :
    (state_reg == ST_R_SET) ? 9'(ACC_CYC - 1) : 9'(PHASE_CYC - 1);
  wire cnt_end = cnt_reg == lim;
  // Program polling: polling flag equals true data when finished
  wire poll_ok = FL_DQ_I[POLLING_FLAG] == wdata_reg[POLLING_FLAG];
  wire poll_err = FL_DQ_I[ERROR_FLAG];
  wire last_write = idx_reg == last_idx;

  // Next state of the pin sequencer
  always_comb begin
    state_next = state_reg;
    done_pulse = 1'b0;
    fail_pulse = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = (PWDATA_I[1:0] != OP_READ) ? ST_W_SET : ST_R_SET;
        end
      end
      ST_W_SET: begin
        if (cnt_end) begin
          state_next = ST_W_LOW;
        end
      end
      ST_W_LOW: begin
        if (cnt_end) begin
          state_next = ST_W_HIGH;
        end
      end
      ST_W_HIGH: begin
        if (cnt_end && !last_write) begin
          state_next = ST_W_SET;
        end else if (cnt_end && op == OP_RESET && ctrl_reg[CTRL_ERASE]) begin
          state_next = ST_WAIT;
        end else if (cnt_end && op == OP_RESET) begin
          state_next = ST_IDLE;
          done_pulse = 1'b1;
        end else if (cnt_end) begin
          state_next = ST_R_SET;  // Identification read or first status poll
        end
      end
      ST_R_SET: begin
        if (cnt_end) begin
          state_next = ST_R_CAP;
        end
      end
      ST_R_CAP: begin
        if (op != OP_PROG || poll_ok) begin
          state_next = ST_IDLE;
          done_pulse = 1'b1;
        end else if (poll_err && retry_reg) begin
          // Error flag set and the re-read still mismatches
          state_next = ST_IDLE;
          done_pulse = 1'b1;
          fail_pulse = 1'b1;
        end else begin
          state_next = ST_R_SET;  // Keep polling while the device is busy
        end
      end
      ST_WAIT: begin
        if (cnt_end) begin
          state_next = ST_IDLE;
          done_pulse = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State, counter and step index
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 9'h0;
      idx_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_next != state_reg) ? 9'h0 : cnt_reg + 9'h1;
      if (state_reg == ST_IDLE) begin
        idx_reg <= 2'h0;
      end else if (state_reg == ST_W_HIGH && cnt_end && !last_write) begin
        idx_reg <= idx_reg + 2'h1;
      end
    end
  end

  // Retry flag for the second look after the error flag shows
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I || state_reg == ST_IDLE) begin
      retry_reg <= 1'b0;
    end else if (state_reg == ST_R_CAP && poll_err && !poll_ok) begin
      retry_reg <= 1'b1;
    end
  end

  // Flash pins; address and data held through the whole strobe
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      FL_ADDR_O <= 20'h0;
      FL_DQ_O <= 8'h0;
      FL_DQ_OE_O <= 1'b0;
      FL_CE_N_O <= 1'b1;
      FL_OE_N_O <= 1'b1;
      FL_WE_N_O <= 1'b1;
    end else begin
      FL_CE_N_O <= !(state_next inside {ST_W_SET, ST_W_LOW, ST_W_HIGH, ST_R_SET, ST_R_CAP});
      FL_WE_N_O <= state_next != ST_W_LOW;
      // Output enable lifts for one cycle between polls, so every status read is a
      // fresh read and the toggle flag can move
      FL_OE_N_O <= !(state_next == ST_R_CAP || (state_next == ST_R_SET && state_reg != ST_R_CAP));
      // Bus released for every read so status bytes can come back
      FL_DQ_OE_O <= state_next inside {ST_W_SET, ST_W_LOW, ST_W_HIGH};
      if (state_next == ST_W_SET && state_reg == ST_IDLE) begin
        // Stored control is not updated yet here, so decode the order on the bus
        FL_ADDR_O <= first_bare ? {8'h0, CMD_ADDR} : {8'h0, UNLOCK1_ADDR};
        FL_DQ_O <= first_bare ? READ_RESET_CMD : UNLOCK1_DATA;
      end else if (state_next == ST_W_SET) begin
        FL_ADDR_O <= step_addr;
        FL_DQ_O <= step_data;
      end else if (state_next == ST_R_SET) begin
        FL_ADDR_O <= addr_reg;   // Low bits pick maker, part or block query
      end
    end
  end

  // Software registers; control is frozen while busy
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ctrl_reg <= 5'h0;
      addr_reg <= 20'h0;
      wdata_reg <= 8'h0;
      mask_reg <= 2'h0;
    end else if (apb_wr && !busy_reg) begin
      if (hit_ctrl) ctrl_reg <= {PWDATA_I[4:3], 1'b0, PWDATA_I[1:0]};
      if (hit_addr) addr_reg <= PWDATA_I[19:0];
      if (hit_wdata) wdata_reg <= PWDATA_I[7:0];
      if (hit_mask) mask_reg <= PWDATA_I[1:0];
    end else if (apb_wr && hit_mask) begin
      mask_reg <= PWDATA_I[1:0];
    end
  end

  // Busy, captured byte and failure result
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      busy_reg <= 1'b0;
      rbyte_reg <= 8'h0;
      fail_reg <= 1'b0;
    end else begin
      busy_reg <= (start | busy_reg) & !done_pulse;
      if (state_reg == ST_R_CAP) rbyte_reg <= FL_DQ_I;
      if (start) fail_reg <= 1'b0;
      else if (fail_pulse) fail_reg <= 1'b1;
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      stat_reg <= 2'h0;
      IRQ_O <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~((apb_wr && hit_stat) ? PWDATA_I[1:0] : 2'h0))
        | {fail_pulse, done_pulse};
      IRQ_O <= |(stat_reg & mask_reg);
    end
  end

  // APB answer: one wait state, error on unmapped offsets
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= RESET_WORD;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && PENABLE_I && !PREADY_O;
      PRDATA_O <= (apb_acc && !PWRITE_I) ? rd_mux : RESET_WORD;
      PSLVERR_O <= apb_acc && !hit_any;
    end
  end

  // Write strobe one cycle ago, for the strobe edge checks below
  logic we_prev_reg;
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      we_prev_reg <= 1'b1;
    end else begin
      we_prev_reg <= FL_WE_N_O;
    end
  end
  wire we_fall = !FL_WE_N_O && we_prev_reg;
  a_unlock_first: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    we_fall && unlock_path && idx_reg == 2'h0 |->
      FL_ADDR_O[11:0] == UNLOCK1_ADDR && FL_DQ_O == UNLOCK1_DATA)
    else $error("first unlock cycle wrong");
  a_unlock_second: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    we_fall && unlock_path && idx_reg == 2'h1 |->
      FL_ADDR_O[11:0] == UNLOCK2_ADDR && FL_DQ_O == UNLOCK2_DATA)
    else $error("second unlock cycle wrong");
  a_auto_cmd: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    we_fall && op == OP_AUTO && idx_reg == 2'h2 |->
      FL_ADDR_O[11:0] == CMD_ADDR && FL_DQ_O == AUTO_SELECT_CMD)
    else $error("auto select command wrong");
  a_prog_cmd: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    we_fall && op == OP_PROG && idx_reg == 2'h2 |-> FL_DQ_O == PROGRAM_CMD)
    else $error("program command wrong");
  a_prog_data: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    we_fall && op == OP_PROG && idx_reg == 2'h3 |->
      FL_ADDR_O == addr_reg && FL_DQ_O == wdata_reg)
    else $error("program data cycle wrong");
  a_reset_cmd: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    we_fall && op == OP_RESET |-> FL_DQ_O == step_data && last_write == (eff_idx == 2'h2))
    else $error("read reset cycle wrong");
  a_reset_wait: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    $rose(state_reg == ST_WAIT) |-> (busy_reg && FL_CE_N_O)[*8] ##[1:400] done_pulse)
    else $error("reset wait too short or unbounded");
  a_strobe_stable: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    !FL_WE_N_O && !$past(FL_WE_N_O) |-> $stable(FL_ADDR_O) && $stable(FL_DQ_O))
    else $error("address or data moved under write strobe");
  a_read_release: assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
    !FL_OE_N_O |-> !FL_DQ_OE_O && FL_WE_N_O)
    else $error("data bus driven during a read");
  c_prog_done: cover property (@(posedge REF_CLK_I) done_pulse && op == OP_PROG && !fail_pulse);
  c_prog_fail: cover property (@(posedge REF_CLK_I) fail_pulse);
  c_auto_done: cover property (@(posedge REF_CLK_I) done_pulse && op == OP_AUTO);
  c_reset_wait: cover property (@(posedge REF_CLK_I) state_reg == ST_WAIT && cnt_end);
endmodule // fci_host

// File: fci_flash_model.sv
// Purpose: Behavioural byte-wide flash seen from the controller pins
// Assumes: Active-low strobes; chip enable already low when the write strobe moves
// Notes: Only 256 array bytes are kept; the ID values are arbitrary
`timescale 1ns/10ps
module fci_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h4D, // Arbitrary value
  parameter logic [6:0] PROT_BLK = 7'h05, // The one protected block
  parameter int BUSY_READS = 3 // Status reads before a program ends
) (
  input wire logic [19:0] addr_i,
  input wire logic [7:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  output logic [7:0] dq_o
);
  logic [7:0] mem [0:255]; // Array bytes, erased to all ones
  logic [19:0] lat_addr = 20'h00000; // Address latched at the strobe fall
  logic [7:0] last = 8'h00; // Last byte put on the bus
  logic [7:0] pdat = 8'h00; // Byte of the running program
  logic id_mode = 1'b0; // Identification page selected
  logic err = 1'b0; // Error flag
  logic tog = 1'b0; // Toggle flag
  logic suspended = 1'b0; // This host never starts an erase, so no suspend is held
  int step = 0; // Position in the command sequence
  int busy = 0; // Status reads left
  wire logic [11:0] a12 = lat_addr[11:0]; // Upper lines are ignored
  // Erased array at start
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // Address is taken on the falling strobe
  always @(negedge we_n_i) begin
    if (!ce_n_i) lat_addr = addr_i;
  end
  // Command decode when the strobe rises, data taken there
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      if (step == 3) begin
        // Raising a stored zero is refused and flagged
        if ((~mem[lat_addr[7:0]] & dq_i) != 8'h00) err = 1'b1;
        mem[lat_addr[7:0]] = mem[lat_addr[7:0]] & dq_i;
        pdat = dq_i;
        busy = BUSY_READS;
        step = 0;
      end else if (dq_i == 8'hF0 && !suspended) begin
        // Read/reset with or without the unlock pair; refused in suspend
        id_mode = 1'b0;
        err = 1'b0;
        busy = 0;
        step = 0;
      end else if (step == 0 && a12 == 12'h555 && dq_i == 8'hAA) step = 1;
      else if (step == 1 && a12 == 12'h2AA && dq_i == 8'h55) step = 2;
      else if (step == 2 && a12 == 12'h555 && dq_i == 8'h90) begin
        id_mode = 1'b1;
        step = 0;
      end else if (step == 2 && a12 == 12'h555 && dq_i == 8'hA0) step = 3;
      else step = 0; // A stray write drops the sequence
    end
  end
  // Each read picks status, ID page or array; the delay lets chip enable settle
  always @(negedge oe_n_i) begin
    #1;
    if (!ce_n_i) begin
      if (busy > 0 || err) begin
        // Erase-block toggle flag reads one during a plain program
        last = {~pdat[7], tog, err, 2'b00, (suspended ? ~tog : 1'b1), 2'b00};
        tog = ~tog; // Alternates on every status read, while busy or while the error flag is set
        if (busy > 0) busy = busy - 1;
      end else if (id_mode) begin
        if (addr_i[1]) last = (addr_i[19:13] == PROT_BLK) ? 8'h01 : 8'h00;
        else last = addr_i[0] ? PART_ID : MAKER_ID;
      end else last = mem[addr_i[7:0]];
    end
  end
  // A released bus shows the inverse, so a stale byte can never pass
  assign dq_o = (!ce_n_i && !oe_n_i) ? last : ~last;
endmodule // fci_flash_model

// File: tb_top.sv
// Purpose: Self-checking bench for the flash command host controller
// Assumes: One APB request in flight; flash model on the pins
// Notes: Expected bytes follow from the command rules and model parameters
`timescale 1ns/10ps
module tb_top;
  import fci_pkg::*;
  logic clk = 1'b0; // 40 MHz clock
  logic rst = 1'b1; // Synchronous reset
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0; // APB controls
  logic [7:0] paddr = 8'h00; // APB address
  logic [31:0] pwdata = 32'h0, prdata, r; // Write data, read data, last read
  logic pready, pslverr, irq, dq_oe, ce_n, oe_n, we_n, e; // Outputs, last error
  logic [19:0] fl_addr; // Flash address pins
  logic [7:0] dq_in, dq_out; // Flash data both ways
  int err_total = 0, n_compared = 0; // Mismatch and comparison counts
  time t0; // Start of the timed reset
  logic [19:0] qa [4] = '{20'h00000, 20'h00001, 20'h0A002, 20'h0C002}; // ID page
  logic [7:0] qe [4] = '{8'h3C, 8'h4D, 8'h01, 8'h00}; // Expected ID page bytes
  // Free-running clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  fci_host uut (.REF_CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq), .FL_ADDR_O(fl_addr),
    .FL_DQ_I(dq_in), .FL_DQ_O(dq_out), .FL_DQ_OE_O(dq_oe), .FL_CE_N_O(ce_n),
    .FL_OE_N_O(oe_n), .FL_WE_N_O(we_n));
  fci_flash_model flash (.addr_i(fl_addr), .dq_i(dq_out), .ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .dq_o(dq_in));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and stop
  task automatic end_sim;
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer: setup, then access until the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 64);
    if (i >= 64) begin
      err_total++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // Poll the busy bit with a bound
  task automatic wait_idle;
    int i;
    i = 0;
    do begin
      apb(1'b0, OFS_RESULT, 32'h0);
      i++;
    end while (r[RES_BUSY] !== 1'b0 && i < 2000);
    if (i >= 2000) begin
      err_total++;
      end_sim();
    end
  endtask
  // Launch one operation and wait for it
  task automatic run(input logic [31:0] ctrl);
    apb(1'b1, OFS_CTRL, ctrl | 32'h4);
    wait_idle();
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Result, status and mask come up clear
    for (int k = 0; k < 3; k++) begin
      apb(1'b0, OFS_RESULT + 8'(4 * k), 32'h0);
      check(r, RESET_WORD);
    end
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    // Program into erased array, upper address lines set
    apb(1'b1, OFS_ADDR, 32'h12345);
    apb(1'b1, OFS_WDATA, 32'h5A);
    run(32'(OP_PROG));
    check(r & 32'h300, 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check(r, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    run(32'(OP_READ));
    check(r & 32'hFF, 32'h5A);
    // Trying to raise bits must fail and leave only cleared bits
    apb(1'b1, OFS_WDATA, 32'hF0);
    run(32'(OP_PROG));
    check(r & 32'h200, 32'h200);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    check(r & 32'h2, 32'h2);
    apb(1'b1, OFS_IRQ_STAT, 32'h3);
    run(32'(OP_RESET) | 32'h10);
    run(32'(OP_READ));
    check(r & 32'hFF, 32'h50);
    // Identification and protection bytes
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFS_ADDR, 32'(qa[k]));
      run(32'(OP_AUTO));
      check(r & 32'hFF, 32'(qe[k]));
    end
    // Single reset write leaves the ID page
    run(32'(OP_RESET));
    apb(1'b1, OFS_ADDR, 32'h12345);
    run(32'(OP_READ));
    check(r & 32'hFF, 32'h50);
    // Reset in erase mode waits; an address write while busy is dropped
    t0 = $time;
    apb(1'b1, OFS_CTRL, 32'(OP_RESET) | 32'hC);
    apb(1'b1, OFS_ADDR, 32'h0);
    wait_idle();
    check({31'h0, ($time - t0) >= RST_WAIT_CYC * 25}, 32'h1);
    apb(1'b0, OFS_ADDR, 32'h0);
    check(r, 32'h12345);
    end_sim();
  end
endmodule // tb_top
